// >>> rtl/pm_cap_regs.sv
// Purpose: Power-management capabilities word and control/status word of a
//          bridge function, reached through configuration reads and writes.
// Assumes: revisionSelect comes from the general control register on the same
//          clock, so it is read without synchronisation.
// Notes:   Read data answers one cycle after the request and shows the value
//          held before any write taken in the same cycle.
`timescale 1ns/100ps
// Summary of operation
// - Capabilities bits 15:11, wake-capable states, always read zero.
// - Capabilities bit 10 reads one: deep doze state supported.
// - Capabilities bit 9 reads one: light doze state supported.
// - Capabilities bits 8:6, auxiliary current, read zero.
// - Capabilities bit 5 reads zero: no special initialisation needed.
// - Capabilities bit 3 reads zero: wake needs no bus clock.
// - Revision field reads 010 when selector clear, 011 when set.
// - Revision selector input drives revision field and no-soft-reset bit.
// - Control bit 15, wake event flag, reads zero and ignores writes.
// - Control bits 14:13, data scale, read zero.
// - Control bits 12:9, data select, read zero.
// - Control bit 8 is a scratch bit, reset zero, no other effect.
// - Control bit 3 reads the revision selector: no soft reset.
// - Leaving hot D3 for D0 causes no internal reset; contents kept.
// - Control bits 1:0 hold power state, reset D0, take written value.
// - Reserved bits read zero in both words.
// - Reset values are 0603h and 0008h with selector set.
module pm_cap_regs
    import pm_cap_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire cfgReq_t cfgReq,
    input wire logic revisionSelect,
    output cfgRsp_t cfgRsp,
    output powerState_t devicePowerState,
    output logic wakeScratchBit,
    output logic powerStateChanged
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic nrstSync;

    pm_reset_sync resetSync (
        .clk(clk),
        .nrst(nrst),
        .nrstSync(nrstSync)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // Bit 0 of the address is ignored; a halfword access names its word by
    // the even offset, and the byte enables pick the lanes within it.
    logic hitCap;
    logic hitCtrl;
    logic wrStateLane;
    logic wrScratchLane;

    always_comb begin
        hitCap = (cfgReq.addr[7:1] == CAP_WORD_OFFSET[7:1]);
        hitCtrl = (cfgReq.addr[7:1] == CTRL_WORD_OFFSET[7:1]);
        wrStateLane = cfgReq.wr && hitCtrl && cfgReq.byteEn[0];
        wrScratchLane = cfgReq.wr && hitCtrl && cfgReq.byteEn[1];
    end

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    powerState_t powerState_q;
    powerState_t powerState_d;
    logic stateChanged_q;
    logic stateChanged_d;

    always_comb begin
        powerState_d = powerState_q;
        if (wrStateLane) begin
            powerState_d = powerState_t'(cfgReq.wrData[POWER_STATE_LSB +: POWER_STATE_W]);
        end
        stateChanged_d = (powerState_d != powerState_q);
    end

    // The state register is cleared only by the function reset; the move out
    // of hot D3 is an ordinary write and leaves every other bit untouched.
    always_ff @(posedge clk or negedge nrstSync) begin
        if (!nrstSync) begin
            powerState_q <= PWR_D0;
            stateChanged_q <= 1'b0;
        end else begin
            powerState_q <= powerState_d;
            stateChanged_q <= stateChanged_d;
        end
    end

    // ------------------------------------------------------------
    // Scratch bit
    // ------------------------------------------------------------
    logic scratch_q;
    logic scratch_d;

    always_comb begin
        scratch_d = scratch_q;
        if (wrScratchLane) begin
            scratch_d = cfgReq.wrData[WAKE_SCRATCH_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrstSync) begin
        if (!nrstSync) begin
            scratch_q <= WAKE_SCRATCH_RESET;
        end else begin
            scratch_q <= scratch_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // All fixed fields come from the word builders, so no write can reach
    // them; only the two held fields above are storage.
    cfgRsp_t rsp_q;
    cfgRsp_t rsp_d;
    logic readCap_q;
    logic readCap_d;
    logic readCtrl_q;
    logic readCtrl_d;

    always_comb begin
        rsp_d.valid = cfgReq.rd;
        rsp_d.data = rsp_q.data;
        readCap_d = 1'b0;
        readCtrl_d = 1'b0;
        if (cfgReq.rd) begin
            if (hitCap) begin
                rsp_d.data = capWord(revisionSelect);
                readCap_d = 1'b1;
            end else if (hitCtrl) begin
                rsp_d.data = ctrlWord(revisionSelect, scratch_q, powerState_q);
                readCtrl_d = 1'b1;
            end else begin
                rsp_d.data = UNMAPPED_READ_VALUE;
            end
        end
    end

    always_ff @(posedge clk or negedge nrstSync) begin
        if (!nrstSync) begin
            rsp_q <= '0;
            readCap_q <= 1'b0;
            readCtrl_q <= 1'b0;
        end else begin
            rsp_q <= rsp_d;
            readCap_q <= readCap_d;
            readCtrl_q <= readCtrl_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cfgRsp = rsp_q;
    assign devicePowerState = powerState_q;
    assign wakeScratchBit = scratch_q;
    assign powerStateChanged = stateChanged_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking checkClk @(posedge clk);
    endclocking
    default disable iff (!nrstSync);

    capWakeZero_a: assert property (readCap_q |-> cfgRsp.data[15:11] == 5'h00)
        else $error("wake-capable states field not zero");

    capDeepDoze_a: assert property (readCap_q |-> cfgRsp.data[10])
        else $error("deep doze support bit not set");

    capLightDoze_a: assert property (readCap_q |-> cfgRsp.data[9])
        else $error("light doze support bit not set");

    capAuxCurrent_a: assert property (readCap_q |-> cfgRsp.data[8:6] == 3'h0)
        else $error("auxiliary current field not zero");

    capSpecialInit_a: assert property (readCap_q |-> !cfgRsp.data[5])
        else $error("special initialisation bit not zero");

    capBusClock_a: assert property (readCap_q |-> !cfgRsp.data[3])
        else $error("wake bus clock bit not zero");

    capRevision_a: assert property (
        cfgReq.rd && hitCap |=> cfgRsp.valid
            && cfgRsp.data[2:0] == ($past(revisionSelect) ? 3'h3 : 3'h2))
        else $error("revision field does not follow selector");

    ctrlNoSoftReset_a: assert property (
        cfgReq.rd && hitCtrl |=> cfgRsp.data[3] == $past(revisionSelect))
        else $error("no-soft-reset bit does not follow selector");

    selectorBoth_a: assert property (
        cfgReq.rd && hitCap ##1 cfgReq.rd && hitCtrl && $stable(revisionSelect)
            |=> cfgRsp.data[3] == $past(cfgRsp.data[0], 1))
        else $error("selector drives the two words differently");

    ctrlWakeFlag_a: assert property (readCtrl_q |-> !cfgRsp.data[15])
        else $error("wake event flag not zero");

    ctrlDataFields_a: assert property (
        readCtrl_q |-> cfgRsp.data[14:13] == 2'h0 && cfgRsp.data[12:9] == 4'h0)
        else $error("data scale or select not zero");

    reservedZero_a: assert property (
        (readCtrl_q |-> cfgRsp.data[7:4] == 4'h0 && !cfgRsp.data[2])
            and (readCap_q |-> !cfgRsp.data[4]))
        else $error("reserved bit reads nonzero");

    scratchWrite_a: assert property (
        wrScratchLane ##1 cfgReq.rd && hitCtrl
            |=> cfgRsp.data[8] == $past(cfgReq.wrData[8], 2))
        else $error("scratch bit did not keep written value");

    stateWrite_a: assert property (
        wrStateLane |=> devicePowerState == $past(cfgReq.wrData[1:0])
            && powerStateChanged == ($past(cfgReq.wrData[1:0]) != $past(devicePowerState)))
        else $error("power state did not take written value");

    readOnlyHold_a: assert property (
        !wrStateLane && !wrScratchLane |=> $stable(devicePowerState) && $stable(wakeScratchBit))
        else $error("held field changed without a lane write");

    hotExitKeeps_a: assert property (
        devicePowerState == PWR_D3_HOT && wrStateLane && !wrScratchLane
            && cfgReq.wrData[1:0] == 2'h0
            |=> devicePowerState == PWR_D0 && $stable(wakeScratchBit) && nrstSync)
        else $error("leaving hot D3 disturbed held contents");

    resetValues_a: assert property (
        $rose(nrstSync) |-> devicePowerState == PWR_D0 && !wakeScratchBit
            && capWord(1'b1) == 16'h0603 && ctrlWord(1'b1, 1'b0, PWR_D0) == 16'h0008)
        else $error("reset values wrong");

    // ------------------------------------------------------------
    // Access port checks
    // ------------------------------------------------------------
    // These watch answer timing and lane isolation. Software relies on both,
    // and a slip here shows up as stale or cross-lane read data, which is much
    // harder to spot from the fixed-field checks above.
    rspValid_a: assert property (cfgReq.rd |=> cfgRsp.valid)
        else $error("read not answered one cycle later");

    rspIdle_a: assert property (!cfgReq.rd |=> !cfgRsp.valid)
        else $error("answer strobe without a read");

    rspDataHold_a: assert property (!cfgReq.rd |=> $stable(cfgRsp.data))
        else $error("read data moved without a read");

    rspResetIdle_a: assert property ($rose(nrstSync) |-> !cfgRsp.valid && !powerStateChanged)
        else $error("outputs active straight after reset release");

    unmappedRead_a: assert property (
        cfgReq.rd && !hitCap && !hitCtrl |=> cfgRsp.data == UNMAPPED_READ_VALUE)
        else $error("unmapped read not zero");

    readOneWord_a: assert property (!(readCap_q && readCtrl_q))
        else $error("read decoded to both words");

    capFixedBits_a: assert property (
        readCap_q |-> cfgRsp.data[15:3] == CAP_WORD_RESET[15:3])
        else $error("fixed capabilities bits differ from reset value");

    ctrlStateRead_a: assert property (
        cfgReq.rd && hitCtrl |=> cfgRsp.data[1:0] == $past(devicePowerState))
        else $error("power state readback wrong");

    ctrlScratchRead_a: assert property (
        cfgReq.rd && hitCtrl |=> cfgRsp.data[8] == $past(wakeScratchBit))
        else $error("scratch bit readback wrong");

    scratchAlone_a: assert property (
        wrScratchLane && !wrStateLane |=> $stable(devicePowerState) && !powerStateChanged)
        else $error("scratch write touched the power state");

    stateAlone_a: assert property (
        wrStateLane && !wrScratchLane |=> $stable(wakeScratchBit))
        else $error("power state write touched the scratch bit");

    capWriteIgnored_a: assert property (
        cfgReq.wr && hitCap |=> $stable(devicePowerState) && $stable(wakeScratchBit))
        else $error("write to capabilities word changed held state");

    changedPulse_a: assert property (
        powerStateChanged |-> $changed(devicePowerState) && $past(wrStateLane))
        else $error("state change flag without a state move");

    changedQuiet_a: assert property (
        !powerStateChanged |-> $stable(devicePowerState))
        else $error("state moved without the change flag");

    hotEntryKeeps_a: assert property (
        wrStateLane && !wrScratchLane && cfgReq.wrData[1:0] == 2'h3
            |=> devicePowerState == PWR_D3_HOT && $stable(wakeScratchBit))
        else $error("entering hot D3 disturbed held contents");

endmodule // pm_cap_regs

// >>> rtl/pm_cap_pkg.sv
// Purpose: Shared constants, types and word builders for the power-management
//          capability register pair.
// Assumes: Configuration accesses are 16-bit halfwords at even byte offsets.
// Notes:   The power state enum relies on default codes 0 to 3 in order.
package pm_cap_pkg;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CAP_WORD_OFFSET = 8'h52;
    localparam logic [7:0] CTRL_WORD_OFFSET = 8'h54;
    localparam logic [15:0] CAP_WORD_RESET = 16'h0603;
    localparam logic [15:0] CTRL_WORD_RESET = 16'h0008;
    localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;

    // ------------------------------------------------------------
    // Capabilities word fields
    // ------------------------------------------------------------
    localparam int WAKE_STATES_LSB = 11;
    localparam int WAKE_STATES_W = 5;
    localparam int DEEP_DOZE_BIT = 10;
    localparam int LIGHT_DOZE_BIT = 9;
    localparam int AUX_CURRENT_LSB = 6;
    localparam int AUX_CURRENT_W = 3;
    localparam int SPECIAL_INIT_BIT = 5;
    localparam int WAKE_BUS_CLOCK_BIT = 3;
    localparam int REVISION_LSB = 0;
    localparam int REVISION_W = 3;
    localparam logic [2:0] REVISION_OLD = 3'h2;
    localparam logic [2:0] REVISION_NEW = 3'h3;

    // ------------------------------------------------------------
    // Control/status word fields
    // ------------------------------------------------------------
    localparam int WAKE_FLAG_BIT = 15;
    localparam int WAKE_SCRATCH_BIT = 8;
    localparam int NO_SOFT_RESET_BIT = 3;
    localparam int POWER_STATE_LSB = 0;
    localparam int POWER_STATE_W = 2;
    localparam logic WAKE_SCRATCH_RESET = 1'b0;

    typedef enum logic [1:0] {
        PWR_D0,
        PWR_D1,
        PWR_D2,
        PWR_D3_HOT
    } powerState_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [1:0] byteEn;
        logic [15:0] wrData;
    } cfgReq_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } cfgRsp_t;

    // Builds the read-only capabilities word from the revision selector.
    function automatic logic [15:0] capWord(input logic revisionSelect);
        logic [15:0] w;
        w = 16'h0000;
        w[WAKE_STATES_LSB +: WAKE_STATES_W] = 5'h00;
        w[DEEP_DOZE_BIT] = 1'b1;
        w[LIGHT_DOZE_BIT] = 1'b1;
        w[AUX_CURRENT_LSB +: AUX_CURRENT_W] = 3'h0;
        w[SPECIAL_INIT_BIT] = 1'b0;
        w[WAKE_BUS_CLOCK_BIT] = 1'b0;
        w[REVISION_LSB +: REVISION_W] = revisionSelect ? REVISION_NEW : REVISION_OLD;
        return w;
    endfunction

    // Builds the control/status word from held state and the revision selector.
    function automatic logic [15:0] ctrlWord(input logic revisionSelect,
                                             input logic scratch,
                                             input powerState_t state);
        logic [15:0] w;
        w = 16'h0000;
        w[WAKE_FLAG_BIT] = 1'b0;
        w[WAKE_SCRATCH_BIT] = scratch;
        w[NO_SOFT_RESET_BIT] = revisionSelect;
        w[POWER_STATE_LSB +: POWER_STATE_W] = state;
        return w;
    endfunction

endpackage

// >>> rtl/pm_reset_sync.sv
// Purpose: Two-stage release synchroniser for the active-low reset.
// Assumes: nrst may assert at any time; release is aligned to clk.
// Notes:   Assertion is immediate, release takes two edges.
`timescale 1ns/100ps
module pm_reset_sync (
    input wire logic clk,
    input wire logic nrst,
    output logic nrstSync
);

    logic stage1_q;
    logic stage2_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign nrstSync = stage2_q;

endmodule // pm_reset_sync

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the power-management capability register pair.
// Assumes: Inputs change on the falling edge; a read answers one cycle after it is taken.
// Notes:   The revision selector is driven both ways so both revision codings are seen.
`timescale 1ns/100ps
module tb_top
    import pm_cap_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    cfgReq_t cfgReq = '0;
    logic revisionSelect = 1'b1;
    cfgRsp_t cfgRsp;
    powerState_t devicePowerState;
    logic wakeScratchBit;
    logic powerStateChanged;
    int fails = 0;
    int checksDone = 0;

    always #20 clk = ~clk;

    pm_cap_regs i_dut (
        .clk(clk),
        .nrst(nrst),
        .cfgReq(cfgReq),
        .revisionSelect(revisionSelect),
        .cfgRsp(cfgRsp),
        .devicePowerState(devicePowerState),
        .wakeScratchBit(wakeScratchBit),
        .powerStateChanged(powerStateChanged)
    );

    // ------------------------------------------------------------
    // Access and comparison helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The answer is looked at in its single valid cycle, one falling edge after the take.
    task automatic readCheck(input logic [7:0] addr, input logic [15:0] exp);
        @(negedge clk);
        cfgReq.rd = 1'b1;
        cfgReq.addr = addr;
        @(negedge clk);
        cfgReq.rd = 1'b0;
        check({15'h0000, cfgRsp.valid}, 16'h0001);
        check(cfgRsp.data, exp);
    endtask

    task automatic doWrite(input logic [7:0] addr, input logic [15:0] data,
                           input logic [1:0] lanes);
        @(negedge clk);
        cfgReq.wr = 1'b1;
        cfgReq.addr = addr;
        cfgReq.wrData = data;
        cfgReq.byteEn = lanes;
        @(negedge clk);
        cfgReq.wr = 1'b0;
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testResetValues();
        check({14'h0000, devicePowerState}, 16'h0000);
        check({15'h0000, wakeScratchBit}, 16'h0000);
        readCheck(CAP_WORD_OFFSET, 16'h0603);
        readCheck(CTRL_WORD_OFFSET, 16'h0008);
    endtask

    task automatic testRevision();
        @(negedge clk);
        revisionSelect = 1'b0;
        readCheck(CAP_WORD_OFFSET, 16'h0602);
        readCheck(CTRL_WORD_OFFSET, 16'h0000);
        @(negedge clk);
        revisionSelect = 1'b1;
        readCheck(CAP_WORD_OFFSET, 16'h0603);
        readCheck(CTRL_WORD_OFFSET, 16'h0008);
    endtask

    // Only the high lane is enabled, so the state field must not move.
    task automatic testScratch();
        doWrite(CTRL_WORD_OFFSET, 16'h0103, 2'b10);
        check({15'h0000, wakeScratchBit}, 16'h0001);
        check({14'h0000, devicePowerState}, 16'h0000);
        readCheck(CTRL_WORD_OFFSET, 16'h0108);
    endtask

    // Walks D1, D2, hot D3 and back to D0, with the scratch bit set throughout.
    task automatic testPowerStates();
        logic [1:0] st;
        for (int s = 1; s <= 4; s++) begin
            st = 2'(s % 4);
            doWrite(CTRL_WORD_OFFSET, {14'h0000, st}, 2'b01);
            check({15'h0000, powerStateChanged}, 16'h0001);
            check({14'h0000, devicePowerState}, {14'h0000, st});
            readCheck(CTRL_WORD_OFFSET, {14'h0042, st});
        end
        check({15'h0000, wakeScratchBit}, 16'h0001);
        doWrite(CTRL_WORD_OFFSET, 16'h0000, 2'b01);
        check({15'h0000, powerStateChanged}, 16'h0000);
    endtask

    task automatic testReadOnly();
        doWrite(CTRL_WORD_OFFSET, 16'hffff, 2'b11);
        readCheck(CTRL_WORD_OFFSET, 16'h010b);
        doWrite(CAP_WORD_OFFSET, 16'hffff, 2'b11);
        readCheck(CAP_WORD_OFFSET, 16'h0603);
        readCheck(8'h60, UNMAPPED_READ_VALUE);
    endtask

    // A read and a write taken together must return the value from before the write.
    task automatic testSameCycle();
        @(negedge clk);
        cfgReq.rd = 1'b1;
        cfgReq.wr = 1'b1;
        cfgReq.addr = CTRL_WORD_OFFSET;
        cfgReq.wrData = 16'h0000;
        cfgReq.byteEn = 2'b11;
        @(negedge clk);
        cfgReq.rd = 1'b0;
        cfgReq.wr = 1'b0;
        check(cfgRsp.data, 16'h010b);
        check({15'h0000, powerStateChanged}, 16'h0001);
        readCheck(CTRL_WORD_OFFSET, 16'h0008);
    endtask

    // A scratch write then reads of both words with no idle cycle between them.
    task automatic testBackToBack();
        @(negedge clk);
        revisionSelect = 1'b0;
        cfgReq.wr = 1'b1;
        cfgReq.addr = CTRL_WORD_OFFSET;
        cfgReq.wrData = 16'h0100;
        cfgReq.byteEn = 2'b10;
        @(negedge clk);
        cfgReq.wr = 1'b0;
        cfgReq.rd = 1'b1;
        @(negedge clk);
        check({15'h0000, cfgRsp.valid}, 16'h0001);
        check(cfgRsp.data, 16'h0100);
        cfgReq.addr = CAP_WORD_OFFSET;
        @(negedge clk);
        check(cfgRsp.data, 16'h0602);
        cfgReq.addr = CTRL_WORD_OFFSET;
        @(negedge clk);
        cfgReq.rd = 1'b0;
        check(cfgRsp.data, 16'h0100);
        revisionSelect = 1'b1;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        testResetValues();
        testRevision();
        testScratch();
        testPowerStates();
        testReadOnly();
        testSameCycle();
        testBackToBack();
        end_of_test();
    end

    // The tests need under a hundred cycles; two thousand leaves ample margin.
    initial begin
        #(40 * 2000);
        fails++;
        end_of_test();
    end
endmodule // tb_top
